/* File: dv/icm_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module icm_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // link wires
    input wire logic scl,
    input wire logic sda,
    input wire logic d_scl_oe,
    input wire logic d_sda_oe,
    // device status
    input wire logic por_busy,
    input wire logic nvm_busy,
    input wire logic io_latch_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    sequence s_bus_idle;
        scl && sda;
    endsequence
    sequence s_busy_hold;
        nvm_busy [*8];
    endsequence
    ////////////////////////////////////////
    a_no_stretch: assert property (!d_scl_oe)
        else $error("device held the clock line");
    a_por_sda_free: assert property (por_busy |-> !d_sda_oe)
        else $error("device drove data during reload");
    a_por_after_rst: assert property ($fell(sys_rst) |-> por_busy [*8])
        else $error("no reload after reset");
    a_por_bounded: assert property (por_busy |-> ##[0:300] !por_busy)
        else $error("reload too long");
    a_sda_scl_low: assert property ($changed(d_sda_oe) |-> !scl)
        else $error("data moved while clock high");
    a_nvm_min_run: assert property ($rose(nvm_busy) |-> s_busy_hold)
        else $error("timed cycle cut short");
    a_nvm_at_stop: assert property ($rose(nvm_busy) |-> s_bus_idle)
        else $error("timed cycle not started at stop");
    // latch copy only moves while clock is low or around a reload
    a_latch_steady: assert property (scl && $past(scl, 2) && !por_busy && !$past(por_busy, 2)
        |-> $stable(io_latch_en))
        else $error("latch enable moved outside a write");
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import icm_pkg::*;
    logic core_clk;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic por_busy;
    logic nvm_busy;
    logic io_latch_en;
    logic [31:0] rd;
    logic er;
    logic [7:0] wd[16];
    logic [7:0] bad[3] = '{8'h20, 8'h18, 8'h16};
    int m[2][256];
    int ptr;
    int n_errors;
    int cmp_count;
    int a;
    int pg;
    icm_if lnk ();
    icm_host icm_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus(lnk.host));
    icm_dev #(.NVM_WRITE_CYCLES(9000), .NVM_ERASE_CYCLES(9000)) icm_dev_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .bus(lnk.dev), .por_busy(por_busy), .nvm_busy(nvm_busy), .io_latch_en(io_latch_en));
    icm_checker icm_checker_i (.core_clk(core_clk), .sys_rst(sys_rst), .scl(lnk.scl), .sda(lnk.sda),
        .d_scl_oe(lnk.d_scl_oe), .d_sda_oe(lnk.d_sda_oe), .por_busy(por_busy), .nvm_busy(nvm_busy),
        .io_latch_en(io_latch_en));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [APB_AW-1:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // one link command, then poll until the engine is idle
    task automatic op(input logic [11:0] c);
        apb(1'b1, CMD_OFS, {20'h0, c});
        do apb(1'b0, STAT_OFS, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
    endtask
    task automatic wr(input logic b, input logic [7:0] ad, input int n, input logic stp);
        op({4'h1, CTRL_CODE, 1'b0, b, 2'b00});
        chk(rd[STAT_NACK_BIT], 1'b0);
        op({4'h0, ad});
        chk(rd[STAT_NACK_BIT], 1'b0);
        for (int i = 0; i < n; i++) begin
            op({2'b00, stp && i == n - 1, 1'b0, wd[i]});
            chk(rd[STAT_NACK_BIT], 1'b0);
            if (!b) m[0][ad + i] = wd[i];
        end
        ptr = ad + n;
    endtask
    task automatic rdseq(input logic b, input int n);
        op({4'h1, CTRL_CODE, 1'b0, b, 2'b01});
        chk(rd[STAT_NACK_BIT], 1'b0);
        for (int i = 0; i < n; i++) begin
            op({i < n - 1, 1'b1, i == n - 1, 1'b0, 8'h00});
            chk(rd[STAT_RX_LSB +: 8], m[b][ptr % 256]);
            if (i < n - 1) ptr++;
        end
    endtask
    task automatic rread(input logic b, input logic [7:0] ad, input int n);
        wr(b, ad, 0, 1'b0);
        rdseq(b, n);
        ptr++;
    endtask
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (100000) @(posedge core_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        a = $urandom(66);
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        chk(por_busy, 1'b1);
        while (por_busy !== 1'b0) @(posedge core_clk);
        apb(1'b0, 8'h08, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        a = $urandom_range(8'h7c);
        foreach (wd[i]) wd[i] = 8'($urandom);
        wr(1'b0, a[7:0], 3, 1'b1);
        rread(1'b0, a[7:0], 2);
        rdseq(1'b0, 1);
        foreach (bad[i]) begin
            op(12'h300 | bad[i]);
            chk(rd[STAT_NACK_BIT], 1'b1);
        end
        pg = $urandom_range(15, 1);
        foreach (wd[i]) wd[i] = 8'($urandom);
        wr(1'b1, 8'(pg * 16), 16, 1'b1);
        foreach (wd[i]) m[1][pg * 16 + i] = m[1][pg * 16 + i] | wd[i];
        chk(nvm_busy, 1'b1);
        wd[0] = 8'h04;
        wr(1'b0, RST_REG, 1, 1'b1);
        chk({nvm_busy, io_latch_en}, 2'b11);
        while (nvm_busy !== 1'b0) @(posedge core_clk);
        wd[0] = 8'hff;
        wr(1'b1, 8'(pg * 16 + 15), 1, 1'b1);
        chk(nvm_busy, 1'b0);
        rread(1'b1, 8'(pg * 16 + 15), 1);
        wd[0] = 8'h06;
        wr(1'b0, RST_REG, 1, 1'b1);
        chk(por_busy, 1'b1);
        while (por_busy !== 1'b0) @(posedge core_clk);
        m[0] = m[1];
        m[0][RST_REG][RST_BIT] = 0;
        @(posedge core_clk);
        chk(io_latch_en, m[0][RST_REG][LATCH_BIT]);
        rread(1'b0, RST_REG, 1);
        rread(1'b0, 8'(pg * 16 + 14), 2);
        wd[0] = 8'(8'h80 | pg);
        wr(1'b0, ERASE_REG, 1, 1'b1);
        chk(nvm_busy, 1'b1);
        while (nvm_busy !== 1'b0) @(posedge core_clk);
        m[0][ERASE_REG] = pg;
        for (int k = 0; k < 16; k++) m[1][pg * 16 + k] = 0;
        rread(1'b0, ERASE_REG, 1);
        rread(1'b1, 8'(pg * 16 + 15), 1);
        end_sim();
    end
endmodule
`default_nettype wire

/* File: verilog/icm_dev.sv */
// Added by the designer: register access over the i2c link.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - control byte: code, block address, read/write
// - block address picks RAM, NONVOLATILE_CONFIG_MEMORY or nothing
// - further write bytes go to next address
// - written byte committed when its ack driven
// - repeated start keeps loaded address for read
// - read control byte acked, then eight bits out
// - read without address starts at pointer
// - acked read bytes continue sequentially until stop
// - stop after write control byte bumps pointer
// - master ends single read with nack, stop
// - reset bit reloads RAM from NONVOLATILE_CONFIG_MEMORY, self-clears
// - outputs released while reload sequence runs
// - byte c8 also holds the io latch enable
// - NONVOLATILE_CONFIG_MEMORY program starts at page-aligned address
// - NONVOLATILE_CONFIG_MEMORY page program is sixteen acked bytes
// - master closes page program with stop
// - stop starts timed NONVOLATILE_CONFIG_MEMORY write cycle
// - RAM access keeps working during NONVOLATILE_CONFIG_MEMORY busy
// - malformed page program leaves NONVOLATILE_CONFIG_MEMORY untouched
// - programming only sets bits; erase clears
// - NONVOLATILE_CONFIG_MEMORY read like RAM, no page limit
// - erase register written by single byte write
// - erase start bit erases selected page
// - erase starts at stop, start bit self-clears
module icm_dev #(
    parameter int unsigned NVM_WRITE_CYCLES = icm_pkg::NVM_WRITE_CYC,
    parameter int unsigned NVM_ERASE_CYCLES = icm_pkg::NVM_ERASE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // i2c link
    icm_if.dev bus,
    // device status
    output logic por_busy,
    output logic nvm_busy,
    output logic io_latch_en
);
    import icm_pkg::*;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        icm_dst_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic nvm_sel;
        logic wr_seen;
        logic first;
        logic dev_ack;
        logic mack;
        logic [4:0] pg_cnt;
        logic pg_ok;
        logic [3:0] pg_base;
        logic er_pend;
        logic rst_pend;
        logic por;
        logic [7:0] por_idx;
        logic busy;
        logic op_erase;
        logic [TMR_W-1:0] tmr;
        logic sda_oe;
        logic latch;
    } icm_dev_t;

    icm_dev_t q;
    icm_dev_t d;
    logic [7:0] ram [MEM_BYTES];
    logic [7:0] nonvolatile_config_memory [MEM_BYTES];
    logic [7:0] pbuf [16];
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic ram_we;
    logic [7:0] ram_wa;
    logic [7:0] ram_wd;
    logic buf_we;
    logic nvm_prog;
    logic nvm_erase;
    logic [7:0] wa;
    logic [7:0] nxt;

    function automatic logic [7:0] rd_byte(input logic sel, input logic [7:0] a);
        return sel ? nonvolatile_config_memory[a] : ram[a];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        ram_we = 1'b0;
        ram_wa = q.ptr;
        ram_wd = q.sh;
        buf_we = 1'b0;
        nvm_prog = 1'b0;
        nvm_erase = 1'b0;
        wa = q.ptr;
        nxt = q.tx;
        // [0] is the first synchroniser stage, [2] the previous sample
        d.scl_s = {q.scl_s[1:0], bus.scl};
        d.sda_s = {q.sda_s[1:0], bus.sda};
        rise = q.scl_s[1] & ~q.scl_s[2];
        fall = ~q.scl_s[1] & q.scl_s[2];
        start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
        stop = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];
        d.latch = ram[RST_REG][LATCH_BIT];
        if (q.por) begin
            // reload one byte a cycle, bus ignored and released
            ram_we = 1'b1;
            ram_wa = q.por_idx;
            ram_wd = nonvolatile_config_memory[q.por_idx];
            if (q.por_idx == RST_REG) begin
                ram_wd[RST_BIT] = 1'b0;
            end
            d.por_idx = q.por_idx + 8'h01;
            if (q.por_idx == 8'hff) begin
                d.por = 1'b0;
            end
            d.st = DS_IDLE;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (start) begin
            d.st = DS_CTRL;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop) begin
            d.st = DS_IDLE;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
            if (q.wr_seen) begin
                d.ptr = q.ptr + 8'h01;
            end
            d.wr_seen = 1'b0;
            if (q.rst_pend) begin
                d.por = 1'b1;
                d.por_idx = 8'h00;
            end
            if (!q.busy) begin
                if (q.pg_ok && q.pg_cnt == PAGE_BYTES) begin
                    d.busy = 1'b1;
                    d.op_erase = 1'b0;
                    d.tmr = TMR_W'(NVM_WRITE_CYCLES);
                end else if (q.er_pend) begin
                    d.busy = 1'b1;
                    d.op_erase = 1'b1;
                    d.tmr = TMR_W'(NVM_ERASE_CYCLES);
                end
            end
            d.pg_ok = 1'b0;
            d.er_pend = 1'b0;
            d.rst_pend = 1'b0;
        end else if (rise) begin
            if (q.cnt < BIT_ACK) begin
                d.sh = {q.sh[6:0], q.sda_s[1]};
                d.cnt = q.cnt + 4'h1;
            end else if (q.cnt == BIT_END) begin
                d.mack = ~q.sda_s[1];
            end
        end else if (fall) begin
            if (q.cnt == BIT_ACK) begin
                d.cnt = BIT_END;
                d.dev_ack = 1'b0;
                d.sda_oe = 1'b0;
                case (q.st)
                    DS_CTRL: begin
                        if (q.sh[7:4] == CTRL_CODE && !q.sh[BLK_BIT2] && !(q.sh[BLK_BIT1] && q.sh[BLK_BIT0])) begin
                            d.dev_ack = 1'b1;
                            d.sda_oe = 1'b1;
                            d.nvm_sel = q.sh[BLK_BIT1];
                            if (q.sh[RW_BIT]) begin
                                d.st = DS_READ;
                                d.tx = rd_byte(q.sh[BLK_BIT1], q.ptr);
                            end else begin
                                d.st = DS_WADDR;
                                d.wr_seen = 1'b1;
                            end
                        end else begin
                            d.st = DS_IDLE;
                        end
                    end
                    DS_WADDR: begin
                        d.dev_ack = 1'b1;
                        d.sda_oe = 1'b1;
                        d.st = DS_WDATA;
                        d.ptr = q.sh;
                        d.first = 1'b1;
                        d.pg_cnt = 5'h00;
                        d.pg_base = q.busy ? q.pg_base : q.sh[7:4];
                        d.pg_ok = q.nvm_sel && (q.sh[3:0] == 4'h0);
                    end
                    DS_WDATA: begin
                        d.dev_ack = 1'b1;
                        d.sda_oe = 1'b1;
                        d.first = 1'b0;
                        wa = q.first ? q.ptr : q.ptr + 8'h01;
                        d.ptr = wa;
                        if (q.nvm_sel) begin
                            buf_we = !q.busy;
                            if (q.pg_cnt == PAGE_BYTES || q.busy) begin
                                d.pg_ok = 1'b0;
                            end else begin
                                d.pg_cnt = q.pg_cnt + 5'h01;
                            end
                        end else begin
                            ram_we = 1'b1;
                            ram_wa = wa;
                            if (wa == RST_REG && q.sh[RST_BIT]) begin
                                d.rst_pend = 1'b1;
                            end
                            if (wa == ERASE_REG) begin
                                d.er_pend = q.sh[ERASE_START_BIT];
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (q.cnt == BIT_END) begin
                d.cnt = 4'h0;
                d.sda_oe = 1'b0;
                if (q.st == DS_READ && (q.dev_ack || q.mack)) begin
                    if (!q.dev_ack) begin
                        d.ptr = q.ptr + 8'h01;
                        nxt = rd_byte(q.nvm_sel, q.ptr + 8'h01);
                    end
                    d.tx = nxt;
                    d.sda_oe = ~nxt[7];
                end else if (q.st == DS_READ) begin
                    d.st = DS_IDLE;
                end
            end else if (q.st == DS_READ && q.cnt != 4'h0) begin
                d.tx = {q.tx[6:0], 1'b1};
                d.sda_oe = ~q.tx[6];
            end
        end
        // timed NONVOLATILE_CONFIG_MEMORY cycle; completion yields to a RAM write in the same cycle
        if (q.busy) begin
            if (q.tmr > TMR_W'(1)) begin
                d.tmr = q.tmr - TMR_W'(1);
            end else if (!ram_we) begin
                d.busy = 1'b0;
                if (q.op_erase) begin
                    nvm_erase = !ram[ERASE_REG][ERASE_AREA_BIT];
                    ram_we = 1'b1;
                    ram_wa = ERASE_REG;
                    ram_wd = ram[ERASE_REG];
                    ram_wd[ERASE_START_BIT] = 1'b0;
                end else begin
                    nvm_prog = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.scl_s <= 3'h7;
            q.sda_s <= 3'h7;
            q.por <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memories; RAM stays usable while the NONVOLATILE_CONFIG_MEMORY cycle runs
    always_ff @(posedge core_clk) begin
        if (ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
        if (buf_we && q.pg_cnt < PAGE_BYTES) begin
            pbuf[q.pg_cnt[3:0]] <= q.sh;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                nonvolatile_config_memory[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (nvm_prog) begin
                    nonvolatile_config_memory[{q.pg_base, 4'(i)}] <= nonvolatile_config_memory[{q.pg_base, 4'(i)}] | pbuf[i];
                end
                if (nvm_erase) begin
                    nonvolatile_config_memory[{ram[ERASE_REG][3:0], 4'(i)}] <= 8'h00;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign bus.d_scl_o = 1'b0;
    assign bus.d_scl_oe = 1'b0;
    assign bus.d_sda_o = 1'b0;
    assign bus.d_sda_oe = q.sda_oe;
    assign por_busy = q.por;
    assign nvm_busy = q.busy;
    assign io_latch_en = q.latch;
endmodule
`default_nettype wire

/* File: verilog/icm_host.sv */
`timescale 1ns/100ps
`default_nettype none
module icm_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [icm_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // i2c link
    icm_if.host bus
);
    import icm_pkg::*;

    typedef struct packed {
        logic [1:0] sda_s;
        icm_hst_t st;
        logic [1:0] ph;
        logic [QTR_W-1:0] qcnt;
        logic [3:0] bitn;
        logic [11:0] cmd;
        logic [7:0] tx;
        logic [7:0] rx;
        logic nack;
        logic scl_oe;
        logic sda_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } icm_host_t;

    icm_host_t q;
    icm_host_t d;
    logic tick;
    logic acc;

    function automatic logic [31:0] reg_rd(input icm_host_t s, input logic [7:0] a);
        if (a == CMD_OFS) begin
            return {20'h00000, s.cmd};
        end
        return {16'h0000, s.rx, 6'h00, s.nack, s.st != HS_IDLE};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d = q;
        d.sda_s = {q.sda_s[0], bus.sda};
        acc = psel & penable;
        tick = (q.st != HS_IDLE) && (q.qcnt == '0);
        d.pready = acc & ~q.pready;
        if (acc && !q.pready) begin
            d.prdata = pwrite ? 32'h00000000 : reg_rd(q, paddr);
            d.pslverr = (paddr != CMD_OFS) && (paddr != STAT_OFS);
        end
        if (q.st != HS_IDLE) begin
            d.qcnt = tick ? QTR_W'(SCL_QTR_CYC - 1) : q.qcnt - QTR_W'(1);
        end
        if (acc && q.pready && pwrite && paddr == CMD_OFS && q.st == HS_IDLE) begin
            d.cmd = pwdata[11:0];
            d.tx = pwdata[7:0];
            d.ph = 2'h0;
            d.bitn = 4'h0;
            d.qcnt = QTR_W'(SCL_QTR_CYC - 1);
            d.st = pwdata[CMD_START_BIT] ? HS_START : HS_BITS;
        end
        if (tick) begin
            d.ph = q.ph + 2'h1;
            case (q.st)
                HS_START: begin
                    case (q.ph)
                        2'h0: d.sda_oe = 1'b0;
                        2'h1: d.scl_oe = 1'b0;
                        2'h2: d.sda_oe = 1'b1;
                        default: begin
                            d.scl_oe = 1'b1;
                            d.st = HS_BITS;
                        end
                    endcase
                end
                HS_BITS: begin
                    case (q.ph)
                        2'h0: begin
                            if (q.bitn == BIT_ACK) begin
                                d.sda_oe = q.cmd[CMD_READ_BIT] & q.cmd[CMD_MACK_BIT];
                            end else begin
                                d.sda_oe = ~q.cmd[CMD_READ_BIT] & ~q.tx[7];
                            end
                        end
                        2'h1: d.scl_oe = 1'b0;
                        2'h2: begin
                            if (q.bitn == BIT_ACK) begin
                                d.nack = q.sda_s[1];
                            end else begin
                                d.rx = {q.rx[6:0], q.sda_s[1]};
                            end
                        end
                        default: begin
                            d.scl_oe = 1'b1;
                            d.tx = {q.tx[6:0], 1'b0};
                            d.bitn = q.bitn + 4'h1;
                            if (q.bitn == BIT_ACK) begin
                                d.st = q.cmd[CMD_STOP_BIT] ? HS_STOP : HS_IDLE;
                            end
                        end
                    endcase
                end
                HS_STOP: begin
                    case (q.ph)
                        2'h0: d.sda_oe = 1'b1;
                        2'h1: d.scl_oe = 1'b0;
                        2'h2: d.sda_oe = 1'b0;
                        default: d.st = HS_IDLE;
                    endcase
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.sda_s <= 2'h3;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign bus.h_scl_o = 1'b0;
    assign bus.h_scl_oe = q.scl_oe;
    assign bus.h_sda_o = 1'b0;
    assign bus.h_sda_oe = q.sda_oe;
endmodule
`default_nettype wire

/* File: verilog/icm_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface icm_if;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_scl_o;
    logic d_scl_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;
    // open-drain wires with pull-ups
    assign scl = ~((h_scl_oe & ~h_scl_o) | (d_scl_oe & ~d_scl_o));
    assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
    modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe, input scl, sda);
    modport dev (output d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, input scl, sda);
endinterface
`default_nettype wire

/* File: verilog/icm_pkg.sv */
`default_nettype none
package icm_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NVM_WRITE_TIME_MS = 20;
    localparam int unsigned NVM_ERASE_TIME_MS = 20;
    localparam int unsigned NVM_WRITE_CYC = NVM_WRITE_TIME_MS * CLK_KHZ;
    localparam int unsigned NVM_ERASE_CYC = NVM_ERASE_TIME_MS * CLK_KHZ;
    localparam int unsigned TMR_W = 21;
    localparam int unsigned SCL_PERIOD_NS = 1000;
    localparam int unsigned SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int unsigned QTR_W = 8;
    ////////////////////////////////////////////////////////////////////////////
    // control byte layout
    localparam logic [3:0] CTRL_CODE = 4'h1;
    localparam int unsigned BLK_BIT2 = 3;
    localparam int unsigned BLK_BIT1 = 2;
    localparam int unsigned BLK_BIT0 = 1;
    localparam int unsigned RW_BIT = 0;
    ////////////////////////////////////////////////////////////////////////////
    // device memory map
    localparam int unsigned MEM_BYTES = 256;
    localparam logic [7:0] RST_REG = 8'hc8;
    localparam int unsigned RST_BIT = 1;
    localparam int unsigned LATCH_BIT = 2;
    localparam logic [7:0] ERASE_REG = 8'he3;
    localparam int unsigned ERASE_START_BIT = 7;
    localparam int unsigned ERASE_AREA_BIT = 4;
    localparam logic [4:0] PAGE_BYTES = 5'h10;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    ////////////////////////////////////////////////////////////////////////////
    // host registers
    localparam int unsigned APB_AW = 8;
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int unsigned CMD_START_BIT = 8;
    localparam int unsigned CMD_STOP_BIT = 9;
    localparam int unsigned CMD_READ_BIT = 10;
    localparam int unsigned CMD_MACK_BIT = 11;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_NACK_BIT = 1;
    localparam int unsigned STAT_RX_LSB = 8;
    ////////////////////////////////////////////////////////////////////////////
    // states
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0, DS_CTRL = 3'h1, DS_WADDR = 3'h3, DS_WDATA = 3'h2, DS_READ = 3'h6
    } icm_dst_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0, HS_START = 2'h1, HS_BITS = 2'h3, HS_STOP = 2'h2
    } icm_hst_t;
endpackage
`default_nettype wire
